// ### design/lspm_defines.vh
/*
  register offsets, reset values and timing counts of the load and speed
  pulse monitor. assumes a 40 mhz system clock and byte addresses on the
  avalon-mm slave port, one 32-bit word per register.
*/
`ifndef LSPM_DEFINES_VH
`define LSPM_DEFINES_VH

// register byte offsets
`define LSPM_OFS_CONFIG     8'h00
`define LSPM_OFS_DELAY      8'h04
`define LSPM_OFS_FAIL_SRC   8'h08
`define LSPM_OFS_PRB_SEL    8'h0c
`define LSPM_OFS_PRB_EDGE   8'h10
`define LSPM_OFS_PRB_PPR    8'h14
`define LSPM_OFS_PRB_MAXT   8'h18
`define LSPM_OFS_PRB_GEAR   8'h1c
`define LSPM_OFS_PRB_INV    8'h20
`define LSPM_OFS_SPD_SRC    8'h24
`define LSPM_OFS_DEV_LIM    8'h28
`define LSPM_OFS_RESPONSE   8'h2c
`define LSPM_OFS_LOAD_SPD   8'h30
`define LSPM_OFS_STATUS     8'h34

// reset values
`define LSPM_RST_CONFIG     2'h1
`define LSPM_RST_DELAY      16'h2710
`define LSPM_RST_FAIL_SRC   9'h000
`define LSPM_RST_PRB_SEL    8'h00
`define LSPM_RST_PRB_EDGE   1'h0
`define LSPM_RST_PRB_PPR    16'h0001
`define LSPM_RST_PRB_MAXT   16'h2710
`define LSPM_RST_PRB_GEAR   16'h0001
`define LSPM_RST_PRB_INV    4'h0
`define LSPM_RST_SPD_SRC    16'h0000
`define LSPM_RST_DEV_LIM    16'h0096
`define LSPM_RST_RESPONSE   8'h00

// mode codes and selector values
`define LSPM_MODE_OFF       2'h0
`define LSPM_MODE_SPEED     2'h2
`define LSPM_PRB_DI1        8'h15
`define LSPM_PRB_DI3        8'h17
`define LSPM_SRC_LOAD_SPD   16'h024a
`define LSPM_FAIL_SRC_EN    8

// status bit positions
`define LSPM_ST_LOAD_FAIL   0
`define LSPM_ST_SPD_DEV     1
`define LSPM_ST_DI_LSB      8

// timing: clock in hz, ms tick, rpm numerator (60 s times clock rate)
`define LSPM_CLK_HZ         40000000
`define LSPM_MS_PER_S       1000
`define LSPM_CYC_PER_MS     (`LSPM_CLK_HZ / `LSPM_MS_PER_S)
`define LSPM_RPM_NUM        32'h8f0d1800

`endif

// ### design/lspm_divider.v
/*
  sequential restoring divider, one quotient bit per clock.
  assumes start is a one-cycle pulse taken only while busy is low.
*/
`default_nettype none

module lspm_divider (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [31:0] numer,
  input  wire [31:0] denom,
  output reg         busy_ff,
  output reg         done_ff,
  output reg  [31:0] quot_ff
);

  reg  [31:0] rem_ff;    // partial remainder
  reg  [31:0] num_ff;    // numerator bits still to shift in
  reg  [31:0] den_ff;    // latched divisor
  reg  [5:0]  cnt_ff;    // bits left
  wire [32:0] trial;     // remainder with next bit shifted in
  wire [32:0] diff;      // trial minus divisor

  assign trial = {rem_ff, num_ff[31]};
  assign diff  = trial - {1'b0, den_ff};

  // one bit per cycle; 32 cycles is far below the shortest pulse gap
  always @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      quot_ff <= 32'h0;
      rem_ff  <= 32'h0;
      num_ff  <= 32'h0;
      den_ff  <= 32'h0;
      cnt_ff  <= 6'h0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        busy_ff <= 1'b1;
        rem_ff  <= 32'h0;
        num_ff  <= numer;
        den_ff  <= (denom == 32'h0) ? 32'h1 : denom; // never divide by zero
        cnt_ff  <= 6'h20;
      end else if (busy_ff) begin
        num_ff <= {num_ff[30:0], 1'b0};
        if (!diff[32]) begin
          rem_ff  <= diff[31:0];
          quot_ff <= {quot_ff[30:0], 1'b1};
        end else begin
          rem_ff  <= trial[31:0];
          quot_ff <= {quot_ff[30:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 6'h1;
        if (cnt_ff == 6'h1) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### design/lspm_top.v
/*
  load and speed pulse monitor: load-failure timer on a selectable digital
  input, probe speed measurement and speed deviation check, registers on an
  avalon-mm slave. assumes one 40 mhz clock, digital inputs from pins
  (asynchronous), motor_on and motor speed from logic on the same clock.
*/
// What this block does
// - config selects off, torque, speed, load-only modes
// - low failure input beyond delay gives fault
// - failure input selectable, reset constant one
// - probe select 21 is DI1, 23 DI3
// - probe pulses up to 32 kHz handled
// - edge select 0 rising, 1 falling
// - speed divided by pulses per revolution
// - no pulse within max time zeros speed
// - every probe pulse restarts timeout
// - probe speed multiplied by gear factor
// - invert mask bit 3 inverts DI3
// - deviation above limit flagged, limit 150
// - deviation triggers chosen response setting
// - deviation must persist for delay time
// - source 586 feeds measured speed to compare
// - deviation check only in mode 2
// - response zero disables deviation evaluation
`default_nettype none
`include "lspm_defines.vh"

module lspm_top #(
  parameter CYC_PER_MS = `LSPM_CYC_PER_MS  // shorten for simulation
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [5:0]  di_pin,
  input  wire        motor_on,
  input  wire [15:0] motor_speed,
  output reg         load_failure_fault,
  output reg         speed_dev_fault,
  output reg  [7:0]  response_code,
  output reg  [15:0] measured_load_speed
);

  // configuration registers
  reg  [1:0]  monitor_config_ff;
  reg  [15:0] monitor_delay_time_ff;     // ms
  reg  [8:0]  failure_input_source_ff;   // bit 8 connect, [2:0] input
  reg  [7:0]  probe_input_select_ff;
  reg         probe_edge_select_ff;
  reg  [15:0] probe_pulses_per_rev_ff;
  reg  [15:0] probe_max_measure_time_ff; // ms
  reg  [15:0] probe_gear_factor_ff;
  reg  [3:0]  probe_invert_mask_ff;
  reg  [15:0] speed_monitor_source_ff;
  reg  [15:0] speed_deviation_limit_ff;
  reg  [7:0]  monitor_response_ff;

  // input synchronisers: three stages, filter on stage two and three
  reg  [5:0]  s1_ff;
  reg  [5:0]  s2_ff;
  reg  [5:0]  s3_ff;
  reg  [5:0]  di_ff;                     // filtered input levels

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      // a change counts only once two stages agree
      always @(posedge clk) begin
        if (rst) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          di_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= di_pin[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            di_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

  // millisecond tick shared by all timers
  reg  [31:0] pre_ff;
  reg         ms_tick_ff;

  always @(posedge clk) begin
    if (rst) begin
      pre_ff     <= 32'h0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= 1'b0;
      if (pre_ff >= CYC_PER_MS - 1) begin
        pre_ff     <= 32'h0;
        ms_tick_ff <= 1'b1;
      end else begin
        pre_ff <= pre_ff + 32'h1;
      end
    end
  end

  // load-failure monitoring
  wire        fail_in;      // selected failure level
  wire        lf_mode;      // modes 1 to 3
  reg  [16:0] low_ms_ff;    // ms the input has stayed low

  // unconnected source reads as constant high, so never a failure
  assign fail_in = failure_input_source_ff[`LSPM_FAIL_SRC_EN] ?
                   di_ff[failure_input_source_ff[2:0]] : 1'b1;
  assign lf_mode = (monitor_config_ff != `LSPM_MODE_OFF);

  always @(posedge clk) begin
    if (rst) begin
      low_ms_ff <= 17'h0;
    end else if (!motor_on || fail_in || !lf_mode) begin
      low_ms_ff <= 17'h0;
    end else if (ms_tick_ff && !low_ms_ff[16]) begin
      low_ms_ff <= low_ms_ff + 17'h1;
    end
  end

  wire lf_event = motor_on && (low_ms_ff > {1'b0, monitor_delay_time_ff});

  // probe path: selection, inversion, edge detect
  reg         prb_sel;      // probe level after inversion
  reg         prb_valid;    // a probe input is routed
  reg         prb_prev_ff;
  wire        prb_edge;

  // probe routing, inversion mask applies per input bit
  always @* begin
    prb_sel   = 1'b0;
    prb_valid = 1'b0;
    case (probe_input_select_ff)
      `LSPM_PRB_DI1: begin
        prb_sel   = di_ff[1] ^ probe_invert_mask_ff[1];
        prb_valid = 1'b1;
      end
      `LSPM_PRB_DI3: begin
        prb_sel   = di_ff[3] ^ probe_invert_mask_ff[3];
        prb_valid = 1'b1;
      end
      default: begin
        prb_sel   = 1'b0;
        prb_valid = 1'b0;
      end
    endcase
  end

  assign prb_edge = prb_valid & (probe_edge_select_ff ?
                    (prb_prev_ff & ~prb_sel) :
                    (~prb_prev_ff & prb_sel));

  // period counter and timeout; 32 khz gives 1250 cycles, room for divide
  reg  [31:0] period_ff;    // cycles since last edge
  reg  [16:0] idle_ms_ff;   // ms since last edge
  reg         have_edge_ff; // one edge seen, period meaningful
  reg         div_go_ff;
  reg  [31:0] div_den_ff;
  wire        timeout;
  wire        div_busy;
  wire        div_done;
  wire [31:0] div_quot;
  wire [47:0] den_full;

  assign timeout  = (idle_ms_ff >= {1'b0, probe_max_measure_time_ff});
  assign den_full = period_ff * probe_pulses_per_rev_ff;

  always @(posedge clk) begin
    if (rst) begin
      prb_prev_ff  <= 1'b0;
      period_ff    <= 32'h0;
      idle_ms_ff   <= 17'h0;
      have_edge_ff <= 1'b0;
      div_go_ff    <= 1'b0;
      div_den_ff   <= 32'h0;
    end else begin
      prb_prev_ff <= prb_sel;
      div_go_ff   <= 1'b0;
      if (prb_edge) begin
        period_ff    <= 32'h1;
        idle_ms_ff   <= 17'h0;
        have_edge_ff <= 1'b1;
        if (have_edge_ff && !timeout && !div_busy) begin
          div_go_ff  <= 1'b1;
          div_den_ff <= (den_full[47:32] != 16'h0) ? 32'hffffffff :
                        den_full[31:0];
        end
      end else begin
        if (period_ff != 32'hffffffff) begin
          period_ff <= period_ff + 32'h1;
        end
        if (ms_tick_ff && !idle_ms_ff[16]) begin
          idle_ms_ff <= idle_ms_ff + 17'h1;
        end
        // stale start edge must not pair with a much later one
        if (timeout || !prb_valid) begin
          have_edge_ff <= 1'b0;
        end
      end
    end
  end

  // rpm = 60 * clock rate / (period cycles * pulses per rev)
  lspm_divider u_div (
    .clk     (clk),
    .rst     (rst),
    .start   (div_go_ff),
    .numer   (`LSPM_RPM_NUM),
    .denom   (div_den_ff),
    .busy_ff (div_busy),
    .done_ff (div_done),
    .quot_ff (div_quot)
  );

  wire [47:0] geared = div_quot * probe_gear_factor_ff;

  // measured speed, saturated to 16 bits, zeroed on timeout
  always @(posedge clk) begin
    if (rst) begin
      measured_load_speed <= 16'h0;
    end else if (timeout || !prb_valid) begin
      measured_load_speed <= 16'h0;
    end else if (div_done) begin
      measured_load_speed <= (geared[47:16] != 32'h0) ? 16'hffff :
                             geared[15:0];
    end
  end

  // speed deviation check
  wire        dev_active;
  wire [15:0] cmp_speed;
  wire [15:0] dev_abs;
  reg  [16:0] dev_ms_ff;

  // comparison only live in speed mode, with source wired and response set
  assign dev_active = (monitor_config_ff == `LSPM_MODE_SPEED) &&
                      (monitor_response_ff != 8'h00);
  assign cmp_speed  = (speed_monitor_source_ff == `LSPM_SRC_LOAD_SPD) ?
                      measured_load_speed : motor_speed;
  assign dev_abs    = (cmp_speed > motor_speed) ? (cmp_speed - motor_speed) :
                      (motor_speed - cmp_speed);

  always @(posedge clk) begin
    if (rst) begin
      dev_ms_ff <= 17'h0;
    end else if (!dev_active || dev_abs <= speed_deviation_limit_ff) begin
      dev_ms_ff <= 17'h0;
    end else if (ms_tick_ff && !dev_ms_ff[16]) begin
      dev_ms_ff <= dev_ms_ff + 17'h1;
    end
  end

  wire dev_event = dev_active && (dev_ms_ff > {1'b0, monitor_delay_time_ff});

  // bus slave: one wait cycle, write lands at the ack edge
  wire acc_ack = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_ack  = avs_write & ~avs_waitrequest;
  wire clr_lf  = wr_ack && (avs_address == `LSPM_OFS_STATUS) &&
                 avs_writedata[`LSPM_ST_LOAD_FAIL];
  wire clr_dev = wr_ack && (avs_address == `LSPM_OFS_STATUS) &&
                 avs_writedata[`LSPM_ST_SPD_DEV];

  // sticky faults, set beats a clear in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      load_failure_fault <= 1'b0;
      speed_dev_fault    <= 1'b0;
      response_code      <= 8'h00;
    end else begin
      if (lf_event) begin
        load_failure_fault <= 1'b1;
      end else if (clr_lf) begin
        load_failure_fault <= 1'b0;
      end
      if (dev_event) begin
        speed_dev_fault <= 1'b1;
        response_code   <= monitor_response_ff;
      end else if (clr_dev) begin
        speed_dev_fault <= 1'b0;
        response_code   <= 8'h00;
      end
    end
  end

  // waitrequest high at rest, low for one cycle per request
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // read mux, unmapped addresses read zero
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0;
    case (avs_address)
      `LSPM_OFS_CONFIG:   nxt_rdata = {30'h0, monitor_config_ff};
      `LSPM_OFS_DELAY:    nxt_rdata = {16'h0, monitor_delay_time_ff};
      `LSPM_OFS_FAIL_SRC: nxt_rdata = {23'h0, failure_input_source_ff};
      `LSPM_OFS_PRB_SEL:  nxt_rdata = {24'h0, probe_input_select_ff};
      `LSPM_OFS_PRB_EDGE: nxt_rdata = {31'h0, probe_edge_select_ff};
      `LSPM_OFS_PRB_PPR:  nxt_rdata = {16'h0, probe_pulses_per_rev_ff};
      `LSPM_OFS_PRB_MAXT: nxt_rdata = {16'h0, probe_max_measure_time_ff};
      `LSPM_OFS_PRB_GEAR: nxt_rdata = {16'h0, probe_gear_factor_ff};
      `LSPM_OFS_PRB_INV:  nxt_rdata = {28'h0, probe_invert_mask_ff};
      `LSPM_OFS_SPD_SRC:  nxt_rdata = {16'h0, speed_monitor_source_ff};
      `LSPM_OFS_DEV_LIM:  nxt_rdata = {16'h0, speed_deviation_limit_ff};
      `LSPM_OFS_RESPONSE: nxt_rdata = {24'h0, monitor_response_ff};
      `LSPM_OFS_LOAD_SPD: nxt_rdata = {16'h0, measured_load_speed};
      `LSPM_OFS_STATUS:   nxt_rdata = {18'h0, di_ff, 6'h0,
                                      speed_dev_fault, load_failure_fault};
      default:            nxt_rdata = 32'h0;
    endcase
  end

  // read data captured on the request edge, stands during the ack cycle
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= nxt_rdata;
    end
  end

  // register writes
  always @(posedge clk) begin
    if (rst) begin
      monitor_config_ff         <= `LSPM_RST_CONFIG;
      monitor_delay_time_ff     <= `LSPM_RST_DELAY;
      failure_input_source_ff   <= `LSPM_RST_FAIL_SRC;
      probe_input_select_ff     <= `LSPM_RST_PRB_SEL;
      probe_edge_select_ff      <= `LSPM_RST_PRB_EDGE;
      probe_pulses_per_rev_ff   <= `LSPM_RST_PRB_PPR;
      probe_max_measure_time_ff <= `LSPM_RST_PRB_MAXT;
      probe_gear_factor_ff      <= `LSPM_RST_PRB_GEAR;
      probe_invert_mask_ff      <= `LSPM_RST_PRB_INV;
      speed_monitor_source_ff   <= `LSPM_RST_SPD_SRC;
      speed_deviation_limit_ff  <= `LSPM_RST_DEV_LIM;
      monitor_response_ff       <= `LSPM_RST_RESPONSE;
    end else if (wr_ack) begin
      case (avs_address)
        `LSPM_OFS_CONFIG:   monitor_config_ff <= avs_writedata[1:0];
        `LSPM_OFS_DELAY:    monitor_delay_time_ff <= avs_writedata[15:0];
        `LSPM_OFS_FAIL_SRC: failure_input_source_ff <= avs_writedata[8:0];
        `LSPM_OFS_PRB_SEL:  probe_input_select_ff <= avs_writedata[7:0];
        `LSPM_OFS_PRB_EDGE: probe_edge_select_ff <= avs_writedata[0];
        `LSPM_OFS_PRB_PPR:  probe_pulses_per_rev_ff <= avs_writedata[15:0];
        `LSPM_OFS_PRB_MAXT: probe_max_measure_time_ff <= avs_writedata[15:0];
        `LSPM_OFS_PRB_GEAR: probe_gear_factor_ff <= avs_writedata[15:0];
        `LSPM_OFS_PRB_INV:  probe_invert_mask_ff <= avs_writedata[3:0];
        `LSPM_OFS_SPD_SRC:  speed_monitor_source_ff <= avs_writedata[15:0];
        `LSPM_OFS_DEV_LIM:  speed_deviation_limit_ff <= avs_writedata[15:0];
        `LSPM_OFS_RESPONSE: monitor_response_ff <= avs_writedata[7:0];
        default: begin
          monitor_config_ff <= monitor_config_ff;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### verif/lspm_chk_sva.sv
/*
  port checker for lspm_top: bus handshake, sticky faults, reset state.
  assumes one clock, synchronous active-high reset, bound by name.
*/
`default_nettype none
`include "lspm_defines.vh"

module lspm_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [5:0]  di_pin,
  input wire logic        motor_on,
  input wire logic [15:0] motor_speed,
  input wire logic        load_failure_fault,
  input wire logic        speed_dev_fault,
  input wire logic [7:0]  response_code,
  input wire logic [15:0] measured_load_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // a status write that clears a fault bit excuses the sticky checks
  wire logic st_wr = avs_write && !avs_waitrequest && avs_address == `LSPM_OFS_STATUS;

  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  req_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered after one wait");
  idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  unmapped_a: assert property (avs_read && avs_waitrequest && avs_address == 8'hfc
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  reset_out_a: assert property ($fell(rst) |-> !load_failure_fault && !speed_dev_fault
    && response_code == 8'h00 && measured_load_speed == 16'h0000) else $error("outputs not reset");
  load_hold_a: assert property (load_failure_fault && !(st_wr && avs_writedata[0])
    |=> load_failure_fault) else $error("load fault dropped");
  dev_hold_a: assert property (speed_dev_fault && !(st_wr && avs_writedata[1])
    |=> speed_dev_fault) else $error("deviation fault dropped");
  load_motor_a: assert property ($rose(load_failure_fault) |-> $past(motor_on))
    else $error("load fault with motor off");
  dev_code_a: assert property ($rose(speed_dev_fault) |-> ##[0:1] response_code != 8'h00)
    else $error("deviation fault with zero response");
  code_idle_a: assert property (!speed_dev_fault && !$past(speed_dev_fault)
    |-> response_code == 8'h00) else $error("response code without fault");
endmodule

bind lspm_top lspm_chk u_lspm_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .di_pin, .motor_on, .motor_speed,
  .load_failure_fault, .speed_dev_fault, .response_code, .measured_load_speed);

`default_nettype wire

// ### verif/lspm_sensor.sv
/*
  proximity sensor model: two pulses with unequal high times, idle low.
  assumes the caller enters burst right after a rising clock edge.
*/
`default_nettype none

module lspm_sensor (
  input  wire logic clk,
  output var  logic pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pulse = 1'b0;

  // unequal highs make rising and falling intervals differ
  task automatic burst(input int hi0, input int lo, input int hi1);
    pulse <= 1'b1;
    repeat (hi0) @(posedge clk);
    pulse <= 1'b0;
    repeat (lo) @(posedge clk);
    pulse <= 1'b1;
    repeat (hi1) @(posedge clk);
    pulse <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### verif/lspm_top_bench.sv
/*
  self-checking bench for lspm_top: registers, load failure, probe, deviation.
  assumes 40 mhz clock and ms tick shortened to 4 cycles.
*/
`default_nettype none
`include "lspm_defines.vh"

module lspm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [5:0]  di_rest = 6'h00;  // static pins
  logic        to_di3 = 1'b0;    // sensor on di3, else di1
  logic        pulse;
  logic        motor_on = 1'b0;
  logic [15:0] motor_speed = 16'h0;
  logic        load_failure_fault;
  logic        speed_dev_fault;
  logic [7:0]  response_code;
  logic [15:0] measured_load_speed;
  logic [31:0] rv;
  wire  [5:0]  di_pin = {di_rest[5:2], pulse & !to_di3, di_rest[0]} | {2'h0, pulse & to_di3, 3'h0};
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          msk[12] = '{3, 'hffff, 'h1ff, 'hff, 1, 'hffff, 'hffff, 'hffff, 'hf, 'hffff,
                           'hffff, 'hff};
  int          rsv[12] = '{1, 10000, 0, 0, 0, 1, 10000, 1, 0, 0, 150, 0};
  int          sel[7] = '{21, 21, 23, 23, 23, 0, 21};
  int          edg[7] = '{0, 1, 0, 0, 1, 0, 0};
  int          p3[7] = '{0, 0, 1, 1, 1, 0, 1};
  int          inv[7] = '{0, 0, 0, 8, 8, 0, 0};
  int          dm[5] = '{2, 2, 3, 2, 2};
  int          dr[5] = '{5, 0, 5, 5, 0};
  int          ds[5] = '{586, 586, 586, 0, 586};
  int          dv[5] = '{150, 400, 400, 400, 151};

  always #12.5 clk = ~clk;

  lspm_top #(.CYC_PER_MS(4)) u_lspm_top (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .di_pin, .motor_on, .motor_speed,
    .load_failure_fault, .speed_dev_fault, .response_code, .measured_load_speed);
  lspm_sensor u_lspm_sensor (.clk, .pulse);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low, released at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rv, e);
  endtask

  task print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: about twice the expected run
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    int i, h0, lo, h1, ppr, gr, ivl, spd, d;
    longint q;
    void'($urandom(32'h8abf));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 12; i++) rdc(8'(4 * i), rsv[i]);
    rdc(8'hfc, 32'h0);
    for (i = 0; i < 12; i++) begin
      d = $urandom;
      wr(8'(4 * i), d);
      rdc(8'(4 * i), d & msk[i]);
    end
    wr(`LSPM_OFS_LOAD_SPD, 32'hffff);
    rdc(`LSPM_OFS_LOAD_SPD, 32'h0);
    // load failure on di0, delay 3 ms
    wr(`LSPM_OFS_CONFIG, 3);
    wr(`LSPM_OFS_DELAY, 3);
    wr(`LSPM_OFS_FAIL_SRC, 0);
    wr(`LSPM_OFS_STATUS, 3);
    motor_on <= 1'b1;
    repeat (60) @(posedge clk);
    check(load_failure_fault, 1'b0);
    di_rest[0] <= 1'b1;
    wr(`LSPM_OFS_FAIL_SRC, 32'h100);
    // short lows never reach the delay
    repeat (8) begin
      di_rest[0] <= 1'b0;
      repeat (10) @(posedge clk);
      di_rest[0] <= 1'b1;
      repeat (3) @(posedge clk);
    end
    check(load_failure_fault, 1'b0);
    di_rest[0] <= 1'b0;
    repeat (8) @(posedge clk);
    check(load_failure_fault, 1'b0);
    repeat (40) @(posedge clk);
    check(load_failure_fault, 1'b1);
    rdc(`LSPM_OFS_STATUS, 32'h1);
    di_rest[0] <= 1'b1;
    repeat (5) @(posedge clk);
    wr(`LSPM_OFS_STATUS, 1);
    rdc(`LSPM_OFS_STATUS, 32'h100);
    wr(`LSPM_OFS_FAIL_SRC, 0);
    // probe: two pulses per case, timeout 500 ms = 2000 cycles
    wr(`LSPM_OFS_PRB_MAXT, 500);
    for (i = 0; i < 7; i++) begin
      h0 = 625 + $urandom % 276;
      lo = 625 + $urandom % 276;
      h1 = 700 + $urandom % 301;
      ppr = 50 + $urandom % 151;
      gr = 1 + $urandom % 3;
      wr(`LSPM_OFS_PRB_SEL, sel[i]);
      wr(`LSPM_OFS_PRB_EDGE, edg[i]);
      wr(`LSPM_OFS_PRB_INV, inv[i]);
      wr(`LSPM_OFS_PRB_PPR, ppr);
      wr(`LSPM_OFS_PRB_GEAR, gr);
      to_di3 <= p3[i][0];
      repeat (2200) @(posedge clk);
      u_lspm_sensor.burst(h0, lo, h1);
      repeat (100) @(posedge clk);
      // rising-edge cases also prove each pulse restarts the timeout
      ivl = (edg[i] ^ (p3[i] & inv[i] >> 3)) ? lo + h1 : h0 + lo;
      q = (64'd2400000000 / (ivl * ppr)) * gr;
      spd = (q > 65535) ? 65535 : int'(q);
      if (!((sel[i] == 21 && p3[i] == 0) || (sel[i] == 23 && p3[i] == 1))) spd = 0;
      check(measured_load_speed, spd[15:0]);
      repeat (2200) @(posedge clk);
      check(measured_load_speed, 16'h0);
    end
    // deviation: load speed now zero, delay 2 ms
    wr(`LSPM_OFS_PRB_SEL, 0);
    wr(`LSPM_OFS_DELAY, 2);
    wr(`LSPM_OFS_DEV_LIM, 150);
    for (i = 0; i < 5; i++) begin
      if (i == 4) dr[4] = 1 + $urandom % 255;
      motor_speed <= 16'h0;
      wr(`LSPM_OFS_STATUS, 3);
      wr(`LSPM_OFS_CONFIG, dm[i]);
      wr(`LSPM_OFS_RESPONSE, dr[i]);
      wr(`LSPM_OFS_SPD_SRC, ds[i]);
      motor_speed <= dv[i][15:0];
      repeat (5) @(posedge clk);
      check(speed_dev_fault, 1'b0);
      repeat (60) @(posedge clk);
      check(speed_dev_fault, i == 4);
      check(response_code, (i == 4) ? dr[4][7:0] : 8'h00);
    end
    motor_speed <= 16'h0;
    wr(`LSPM_OFS_STATUS, 2);
    repeat (3) @(posedge clk);
    check(response_code, 8'h00);
    print_verdict;
  end
endmodule

`default_nettype wire
